// *** core/holdover_recovery_tuning_control.v ***
// Holdover control: recovery timers, sampler/averager, hold word, clipper.
// Assumes all inputs other than pins come from logic on clk_sys;
// fault flags and the holdover pin are asynchronous and synchronised here.
// Function
// - Separate recovery timer per reference input
// - Timer starts when both faults clear
// - Expiry flags reference valid for selection
// - Shared 5-bit interval code, reset zero
// - Duration is tick period times 2^(T+1)-1
// - Disable bit ignores timers, uses validation bits
// - Validation bit acts like timer expiry
// - Holdover applies static tuning word
// - Averager feeds averaged or last word
// - Manual exit resumes loop from hold word
// - Auto exit switches when reference valid
// - Averager output to trace and hold logic
// - Hold value is last clipped word or previous sampler output
// - Default passes samples at loop rate
// - Averaging block of 2^(Y+1) samples
// - Two-stage pipeline, hold uses last stage
// - Clip tuning word to 48-bit bounds
// - Bounds reset to half rate and zero
`timescale 1ns/1ps
`include "holdover_defines.vh"
module holdover_recovery_tuning_control (
  input  wire                        clk_sys,
  input  wire                        sys_rst,
  // Reference fault conditions (asynchronous)
  input  wire                        loss_of_reference_first,
  input  wire                        lock_loss_condition_first,
  input  wire                        loss_of_reference_second,
  input  wire                        lock_loss_condition_second,
  // Recovery configuration
  input  wire [`RCV_CODE_WIDTH-1:0]  recovery_code,
  input  wire                        recovery_timer_disable,
  input  wire                        validate_first_reference,
  input  wire                        validate_second_reference,
  // Holdover control
  input  wire                        auto_holdover,
  input  wire                        holdover_pin,
  input  wire                        sm_holdover,
  input  wire                        auto_recovery,
  input  wire                        hold_source_last,
  // Sampler/averager configuration
  input  wire                        averager_enable,
  input  wire                        average_select,
  input  wire [`AVG_CODE_WIDTH-1:0]  average_length_code,
  input  wire [`RATE_EXP_WIDTH-1:0]  rate_exponent,
  // Loop filter and bounds
  input  wire [`TW_WIDTH-1:0]        loop_tuning_word,
  input  wire                        loop_tuning_valid,
  input  wire [`TW_WIDTH-1:0]        tuning_upper_bound,
  input  wire [`TW_WIDTH-1:0]        tuning_lower_bound,
  input  wire                        bounds_load,
  // Outputs; all come from flip-flops, so no path
  // runs straight from an input to an output
  output reg                         first_reference_valid,
  output reg                         second_reference_valid,
  output reg                         holdover_active,
  output reg                         loop_restart,
  output reg                         auto_switch_request,
  output reg                         auto_switch_second,
  output reg  [`TW_WIDTH-1:0]        synth_tuning_word,
  output reg  [`TW_WIDTH-1:0]        trace_word,
  output reg                         trace_strobe,
  output reg  [`TW_WIDTH-1:0]        loop_seed_word
);

  // Two-flop synchronisers for the pin-side inputs.
  // Fault levels and the pin come from other domains.
  // Only stage two is read by logic, so a metastable
  // first stage has a full cycle to settle.
  // Cost: each pin event arrives two cycles late.
  // No filtering here; chatter is left to the timers.
  reg [4:0] sync1_reg;   // First stage, read only by second stage
  reg [4:0] sync2_reg;   // Second stage, safe to use
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {holdover_pin, lock_loss_condition_second,
                    loss_of_reference_second, lock_loss_condition_first,
                    loss_of_reference_first};
      sync2_reg <= sync1_reg;
    end
  end
  wire los_a  = sync2_reg[0];
  wire lol_a  = sync2_reg[1];
  wire los_b  = sync2_reg[2];
  wire lol_b  = sync2_reg[3];
  wire hpin_s = sync2_reg[4];
  // Bundle order: first loss, first lock loss,
  // second loss, second lock loss, holdover pin.

  // Loop-filter tick divider: period 2^rate_exponent system cycles.
  // A one-cycle enable, not a derived clock, so the
  // timers stay in the one clock domain.
  // Exponent zero gives an enable on every cycle.
  // A new exponent acts at once; a count above the
  // new top wraps, so one tick may come early.
  // The sampler does not use it: loop words carry
  // their own valid strobe.
  reg  [`TICK_CNT_WIDTH-1:0] tick_cnt_reg;
  reg                        tick_reg;     // One-cycle enable pulse
  wire [`TICK_CNT_WIDTH-1:0] tick_top;
  assign tick_top = ({{(`TICK_CNT_WIDTH-1){1'b0}}, 1'b1} << rate_exponent)
                    - {{(`TICK_CNT_WIDTH-1){1'b0}}, 1'b1};
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_cnt_reg <= {`TICK_CNT_WIDTH{1'b0}};
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= tick_top) begin
      tick_cnt_reg <= {`TICK_CNT_WIDTH{1'b0}};
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + {{(`TICK_CNT_WIDTH-1){1'b0}}, 1'b1};
      tick_reg     <= 1'b0;
    end
  end

  // Interval code is held here; resets to zero.
  // One register feeds both timers, so they never
  // disagree on the interval.
  reg [`RCV_CODE_WIDTH-1:0] rcv_code_reg;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rcv_code_reg <= `RCV_CODE_RST;
    end else begin
      rcv_code_reg <= recovery_code;
    end
  end

  // One dedicated timer per reference, sharing the interval code.
  // Held clear while either fault stands, counting
  // once both are gone, back to zero if a fault
  // returns: a chattering input never passes.
  wire exp_a;
  wire exp_b;
  recovery_timer timer_first (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .tick      (tick_reg),
    .loss_ref  (los_a),
    .lock_loss (lol_a),
    .rcv_code  (rcv_code_reg),
    .expired   (exp_a)
  );
  recovery_timer timer_second (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .tick      (tick_reg),
    .loss_ref  (los_b),
    .lock_loss (lol_b),
    .rcv_code  (rcv_code_reg),
    .expired   (exp_b)
  );

  // Validity: timer expiry, or software validation when timers disabled.
  // Raw fault clearing is never passed on directly.
  // Disable mode: validate bits act as expiry, one
  // cycle later, like a timer. Software must confirm
  // recovery first; nothing here checks it.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      first_reference_valid  <= 1'b0;
      second_reference_valid <= 1'b0;
    end else if (recovery_timer_disable) begin
      first_reference_valid  <= validate_first_reference;
      second_reference_valid <= validate_second_reference;
    end else begin
      first_reference_valid  <= exp_a;
      second_reference_valid <= exp_b;
    end
  end

  // Clipper on the incoming loop word; bounds load at reset to defaults.
  // Both bounds load on one strobe, so a new upper
  // bound never pairs with an old lower one.
  // Limitation: lower above upper is not caught.
  // Words above upper get upper, those below lower get lower.
  reg  [`TW_WIDTH-1:0] upper_reg;
  reg  [`TW_WIDTH-1:0] lower_reg;
  wire [`TW_WIDTH-1:0] clipped;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      upper_reg <= `TW_UPPER_RST;
      lower_reg <= `TW_LOWER_RST;
    end else if (bounds_load) begin
      upper_reg <= tuning_upper_bound;
      lower_reg <= tuning_lower_bound;
    end
  end
  tuning_clipper clip (
    .tw_in  (loop_tuning_word),
    .upper  (upper_reg),
    .lower  (lower_reg),
    .tw_out (clipped)
  );

  // Sampler/averager: pass-through by default, block average if selected.
  // Samples are taken on valid loop words, which arrive at the tick rate.
  // Samples are clipped first, so a hold word is
  // inside the bounds that were in force when it was sampled.
  // The sum holds 2^16 full-scale words, the
  // longest block, so it cannot overflow.
  reg  [`ACC_WIDTH-1:0] acc_reg;
  reg  [16:0]           acc_cnt_reg;         // Samples in current block
  reg  [`TW_WIDTH-1:0]  pipe0_reg;           // First pipeline stage
  reg  [`TW_WIDTH-1:0]  pipe1_reg;           // Last stage, feeds hold
  reg  [`TW_WIDTH-1:0]  last_word_reg;       // Last valid clipped word
  wire [16:0]           blk_len;
  wire [`ACC_WIDTH-1:0] acc_sum;
  wire [4:0]            avg_shift;
  assign blk_len   = 17'h0_0001 << avg_shift;
  assign avg_shift = {1'b0, average_length_code} + 5'h01;
  assign acc_sum   = acc_reg + {{(`ACC_WIDTH-`TW_WIDTH){1'b0}}, clipped};

  // Accumulate and deliver one result per block into the pipeline.
  // Two stages keep a hold word whose block ended
  // well before holdover; the newest result may
  // stem from a block that entry cut short.
  // Turning the averager off drops a partial
  // block, so the next block starts clean.
  // The trace word sees every result, pass-through
  // or average, with one strobe each.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_reg       <= {`ACC_WIDTH{1'b0}};
      acc_cnt_reg   <= 17'h0_0000;
      pipe0_reg     <= {`TW_WIDTH{1'b0}};
      pipe1_reg     <= {`TW_WIDTH{1'b0}};
      last_word_reg <= {`TW_WIDTH{1'b0}};
      trace_word    <= {`TW_WIDTH{1'b0}};
      trace_strobe  <= 1'b0;
    end else begin
      trace_strobe <= 1'b0;
      if (loop_tuning_valid && !holdover_active) begin
        last_word_reg <= clipped;
      end
      // Frozen during holdover so the hold word stays intact
      if (averager_enable && loop_tuning_valid && !holdover_active) begin
        if (!average_select) begin
          pipe0_reg    <= clipped;
          pipe1_reg    <= pipe0_reg;
          trace_word   <= clipped;
          trace_strobe <= 1'b1;
        end else if (acc_cnt_reg + 17'h0_0001 >= blk_len) begin
          pipe0_reg    <= avg_word(acc_sum, avg_shift);
          pipe1_reg    <= pipe0_reg;
          trace_word   <= avg_word(acc_sum, avg_shift);
          trace_strobe <= 1'b1;
          acc_reg      <= {`ACC_WIDTH{1'b0}};
          acc_cnt_reg  <= 17'h0_0000;
        end else begin
          acc_reg     <= acc_sum;
          acc_cnt_reg <= acc_cnt_reg + 17'h0_0001;
        end
      end else if (!averager_enable) begin
        acc_reg     <= {`ACC_WIDTH{1'b0}};
        acc_cnt_reg <= 17'h0_0000;
      end
    end
  end

  // Divides an accumulated sum by a power of two.
  // Shared by trace and pipeline, so both agree;
  // the shift truncates, rounding towards zero.
  function [`TW_WIDTH-1:0] avg_word;
    input [`ACC_WIDTH-1:0] sum;
    input [4:0]            sh;
    reg   [`ACC_WIDTH-1:0] q;
    begin
      q        = sum >> sh;
      avg_word = q[`TW_WIDTH-1:0];
    end
  endfunction

  // Holdover decision: manual follows the pin, auto follows the machine.
  // The hold word is caught on the entry cycle only,
  // so the synthesizer sees one static word.
  // Source: last clipped word or pipeline's last
  // stage; with the averager off the pipeline is
  // stale, so the last word is used instead.
  // Auto exit: with auto recovery, holdover ends
  // the cycle after either reference is valid.
  // If the request still stands then, holdover is
  // entered again and a fresh word is caught.
  wire hold_req;
  reg  hold_q_reg;          // Previous holdover state for edge detect
  reg  [`TW_WIDTH-1:0] hold_word_reg;
  assign hold_req = auto_holdover ? sm_holdover : hpin_s;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      holdover_active <= 1'b0;
      hold_q_reg      <= 1'b0;
      hold_word_reg   <= {`TW_WIDTH{1'b0}};
    end else begin
      hold_q_reg <= holdover_active;
      if (auto_holdover && auto_recovery && holdover_active &&
          (first_reference_valid || second_reference_valid)) begin
        holdover_active <= 1'b0;
      end else begin
        holdover_active <= hold_req;
      end
      // Capture hold word on entry from the chosen source
      if (hold_req && !holdover_active) begin
        hold_word_reg <= (hold_source_last == `HOLD_SRC_LAST ||
                          !averager_enable) ? last_word_reg
                                            : pipe1_reg;
      end
    end
  end

  // Synthesizer word, loop restart and auto switch outputs.
  // Outside holdover the clipped word passes with
  // one cycle of delay; inside, the hold word stands.
  // On exit the loop restarts once, seeded with the
  // hold word, so it resumes from that frequency.
  // The auto switch names the reference to take:
  // the first if valid, otherwise the second.
  // Pulses last one cycle; levels stand until the
  // next exit changes them.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      synth_tuning_word   <= `TW_LOWER_RST;
      loop_restart        <= 1'b0;
      loop_seed_word      <= {`TW_WIDTH{1'b0}};
      auto_switch_request <= 1'b0;
      auto_switch_second  <= 1'b0;
    end else begin
      loop_restart        <= 1'b0;
      auto_switch_request <= 1'b0;
      if (holdover_active) begin
        synth_tuning_word <= hold_word_reg;
      end else begin
        synth_tuning_word <= clipped;
      end
      if (hold_q_reg && !holdover_active) begin
        loop_restart   <= 1'b1;
        loop_seed_word <= hold_word_reg;
        if (auto_holdover && auto_recovery) begin
          auto_switch_request <= 1'b1;
          auto_switch_second  <= !first_reference_valid;
        end
      end
    end
  end
endmodule // holdover_recovery_tuning_control

// *** core/holdover_defines.vh ***
// Constants for the holdover, recovery and tuning-limit block.
// Assumes a single 200 MHz system clock; included by bare name.
`ifndef HOLDOVER_DEFINES_VH
`define HOLDOVER_DEFINES_VH
// Data widths
`define TW_WIDTH        48
`define RCV_CODE_WIDTH  5
`define AVG_CODE_WIDTH  4
`define RATE_EXP_WIDTH  5
// Reset values
`define RCV_CODE_RST    5'h00
`define AVG_CODE_RST    4'h0
`define RATE_EXP_RST    5'h00
// Upper bound resets to half the sample rate, lower bound to zero
`define TW_UPPER_RST    48'h8000_0000_0000
`define TW_LOWER_RST    48'h0000_0000_0000
// Tick divider and timer counter widths
`define TICK_CNT_WIDTH  32
`define RCV_CNT_WIDTH   33
// Accumulator width: 48-bit words times up to 65536 samples
`define ACC_WIDTH       65
// Hold source select codes
`define HOLD_SRC_SAMPLER 1'b0
`define HOLD_SRC_LAST    1'b1
`endif

// *** core/recovery_timer.v ***
// One recovery timer for one reference input.
// Assumes tick is a one-cycle pulse at the loop-filter sample rate.
`timescale 1ns/1ps
`include "holdover_defines.vh"
module recovery_timer (
  input  wire                         clk_sys,
  input  wire                         sys_rst,
  input  wire                         tick,        // Loop-filter sample tick
  input  wire                         loss_ref,    // Reference lost
  input  wire                         lock_loss,   // Reference out of lock
  input  wire [`RCV_CODE_WIDTH-1:0]   rcv_code,    // Shared interval code
  output reg                          expired      // Timer has run out
);
  reg  [`RCV_CNT_WIDTH-1:0] count_reg;   // Elapsed ticks
  wire [`RCV_CNT_WIDTH-1:0] limit;       // Ticks to expiry
  wire                      fault;

  assign fault = loss_ref | lock_loss;
  // Duration 2^(T+1)-1 ticks
  // Shift amount widened so that code 31 does not wrap to zero
  assign limit = ({{(`RCV_CNT_WIDTH-1){1'b0}}, 1'b1} << ({1'b0, rcv_code} + 6'h01))
                 - {{(`RCV_CNT_WIDTH-1){1'b0}}, 1'b1};

  // Count only once both faults are clear; any fault restarts from zero
  always @(posedge clk_sys) begin
    if (sys_rst || fault) begin
      count_reg <= {`RCV_CNT_WIDTH{1'b0}};
      expired   <= 1'b0;
    end else if (!expired && tick) begin
      if (count_reg + {{(`RCV_CNT_WIDTH-1){1'b0}}, 1'b1} >= limit) begin
        expired <= 1'b1;
      end
      count_reg <= count_reg + {{(`RCV_CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // recovery_timer

// *** core/tuning_clipper.v ***
// Clamps a tuning word between programmable bounds.
// Assumes bounds are unsigned and lower not above upper.
`timescale 1ns/1ps
`include "holdover_defines.vh"
module tuning_clipper (
  input  wire [`TW_WIDTH-1:0] tw_in,        // Word from loop filter
  input  wire [`TW_WIDTH-1:0] upper,        // Upper bound
  input  wire [`TW_WIDTH-1:0] lower,        // Lower bound
  output reg  [`TW_WIDTH-1:0] tw_out        // Clipped word
);
  // Combinational clip; the caller registers the result
  always @* begin
    if (tw_in > upper) begin
      tw_out = upper;
    end else if (tw_in < lower) begin
      tw_out = lower;
    end else begin
      tw_out = tw_in;
    end
  end
endmodule // tuning_clipper

// *** test/ref_pair_model.sv ***
// Model of the two reference inputs and the holdover state machine.
// Assumes the bench commands failures; fault levels move after the rising edge.
`timescale 1ns/1ps
module ref_pair_model (
  input  wire clk_sys,     // System clock
  input  wire fail_first,  // Command: first reference faulty
  input  wire fail_second, // Command: second reference faulty
  input  wire ref_ok,      // A reference is flagged valid
  output reg  loss_first,  // First reference lost
  output reg  lock_first,  // First reference out of lock
  output reg  loss_second, // Second reference lost
  output reg  lock_second, // Second reference out of lock
  output reg  sm_hold      // Holdover request
);
  initial {loss_first, lock_first, loss_second, lock_second, sm_hold} = 5'h00;
  // Lock loss clears a cycle after loss, so recovery has to wait for both
  always @(posedge clk_sys) begin
    loss_first  <= fail_first;
    lock_first  <= loss_first;
    loss_second <= fail_second;
    lock_second <= loss_second;
    // Sticky until a reference is valid again, like the real machine
    sm_hold     <= (sm_hold | (fail_first & fail_second)) & ~ref_ok;
  end
endmodule // ref_pair_model

// *** test/holdover_checks_properties.sv ***
// Timing checks on the holdover control block's ports.
// Assumes one clock domain and the block's synchronous reset.
`timescale 1ns/1ps
module holdover_checks (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        lock_loss_condition_first,
  input wire        lock_loss_condition_second,
  input wire        recovery_timer_disable,
  input wire        validate_second_reference,
  input wire        auto_holdover,
  input wire        sm_holdover,
  input wire        auto_recovery,
  input wire        first_reference_valid,
  input wire        second_reference_valid,
  input wire        holdover_active,
  input wire        loop_restart,
  input wire [47:0] synth_tuning_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  fault_first_a: assert property ($rose(lock_loss_condition_first) &&
    !recovery_timer_disable |-> ##[1:5] !first_reference_valid) else $error("first valid kept");
  fault_second_a: assert property ($rose(lock_loss_condition_second) &&
    !recovery_timer_disable |-> ##[1:5] !second_reference_valid) else $error("second valid kept");
  valid_after_clear_a: assert property ($rose(first_reference_valid) &&
    !recovery_timer_disable |-> !$past(lock_loss_condition_first, 3)) else $error("early valid");
  validate_follow_a: assert property (recovery_timer_disable &&
    $past(recovery_timer_disable) && !$past(sys_rst) |->
    second_reference_valid == $past(validate_second_reference))
    else $error("validate bit not followed");
  hold_entry_a: assert property ($rose(sm_holdover) && auto_holdover &&
    !first_reference_valid && !second_reference_valid |=> holdover_active) else $error("no hold");
  hold_static_a: assert property (holdover_active[*3] |->
    $stable(synth_tuning_word)) else $error("tuning word moved in holdover");
  restart_pulse_a: assert property ($fell(holdover_active) |->
    ##[0:1] loop_restart) else $error("no loop restart on exit");
  auto_exit_a: assert property (auto_holdover && auto_recovery && holdover_active &&
    (first_reference_valid || second_reference_valid) |=> !holdover_active) else $error("no exit");
endmodule // holdover_checks
bind holdover_recovery_tuning_control holdover_checks u_chk (.clk_sys, .sys_rst,
  .lock_loss_condition_first, .lock_loss_condition_second, .recovery_timer_disable,
  .validate_second_reference, .auto_holdover, .sm_holdover, .auto_recovery,
  .first_reference_valid, .second_reference_valid, .holdover_active, .loop_restart,
  .synth_tuning_word);

// *** test/holdover_recovery_tuning_control_tb.sv ***
// Bench for the holdover block: sampler, hold word, timers and bounds.
// Assumes the bound checker and the reference model stand beside the design.
`timescale 1ns/1ps
module holdover_recovery_tuning_control_tb;
  reg         clk_sys = 1'b0;             // 200 MHz clock
  reg         sys_rst = 1'b1;             // Synchronous reset
  reg         fail1 = 1'b0, fail2 = 1'b0; // Fault commands to the model
  reg         recovery_timer_disable, validate_first_reference, validate_second_reference;
  reg         auto_holdover, holdover_pin, auto_recovery, hold_source_last, bounds_load;
  reg         averager_enable, average_select, loop_tuning_valid;
  reg  [4:0]  recovery_code, rate_exponent;
  reg  [3:0]  average_length_code;
  reg  [47:0] loop_tuning_word, tuning_upper_bound, tuning_lower_bound;
  wire        loss_of_reference_first, lock_loss_condition_first, sm_holdover;
  wire        loss_of_reference_second, lock_loss_condition_second, holdover_active;
  wire        first_reference_valid, second_reference_valid, loop_restart;
  wire        auto_switch_request, auto_switch_second, trace_strobe;
  wire [47:0] synth_tuning_word, trace_word, loop_seed_word;
  reg  [47:0] exp_q[$];                   // Expected sampler outputs, oldest first
  reg  [47:0] up_v, lo_v, w, c, c_prev, hw; // Bounds, recent samples, hold word
  reg  [64:0] acc = 65'h0;                // Block sum
  integer     blk = 0, sh, k = 0, j, n, n0, seed = 25, total_checks = 0, n_mismatch = 0;
  reg         hold_now = 1'b0;            // Sampler must ignore samples
  ref_pair_model u_ref (.clk_sys, .fail_first(fail1), .fail_second(fail2),
    .ref_ok(first_reference_valid | second_reference_valid),
    .loss_first(loss_of_reference_first), .lock_first(lock_loss_condition_first),
    .loss_second(loss_of_reference_second), .lock_second(lock_loss_condition_second),
    .sm_hold(sm_holdover));
  holdover_recovery_tuning_control u_dut (.*);
  always #2.5 clk_sys = ~clk_sys;
  // Compare and count; four-state so an unknown never matches
  task chk(input [47:0] seen, input [47:0] want);
    begin
      total_checks = total_checks + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
      end
    end
  endtask
  function [47:0] clip(input [47:0] v);
    clip = (v > up_v) ? up_v : ((v < lo_v) ? lo_v : v);
  endfunction
  // Back-to-back random samples; notes what the sampler should emit
  task burst(input integer cnt);
    integer i;
    begin
      for (i = 0; i < cnt; i = i + 1) begin
        w = {$random(seed), $random(seed)};
        c_prev = c;
        c = clip(w);
        loop_tuning_word = w;
        loop_tuning_valid = 1'b1;
        acc = acc + c;
        k = k + 1;
        if (!hold_now && k >= blk) begin
          exp_q.push_back(blk ? acc >> sh : c);
          acc = 65'h0;
          k = 0;
        end
        @(negedge clk_sys);
      end
      loop_tuning_valid = 1'b0;
      @(negedge clk_sys);
    end
  endtask
  // Each sampler output retires the oldest note; an empty queue always mismatches
  always @(posedge clk_sys) if (trace_strobe === 1'b1)
    chk(trace_word, exp_q.size() ? exp_q.pop_front() : ~trace_word);
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // The run needs well under a thousand cycles; this is far beyond it
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    {recovery_timer_disable, validate_first_reference, validate_second_reference} = 3'h0;
    {auto_holdover, holdover_pin, auto_recovery, hold_source_last, bounds_load} = 5'h00;
    {average_select, loop_tuning_valid, recovery_code, average_length_code} = 11'h000;
    {averager_enable, rate_exponent, loop_tuning_word} = {1'b1, 53'h0};
    tuning_upper_bound = 48'h0000_0000_1000;
    tuning_lower_bound = 48'h0000_0000_0800;
    up_v = 48'h8000_0000_0000;
    lo_v = 48'h0000_0000_0000;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    burst(6);
    tuning_upper_bound = 48'h4000_0000_0000;
    tuning_lower_bound = 48'h1000_0000_0000;
    bounds_load = 1'b1;
    @(negedge clk_sys);
    bounds_load = 1'b0;
    up_v = tuning_upper_bound;
    lo_v = tuning_lower_bound;
    burst(10);
    average_select = 1'b1;
    for (j = 0; j < 2; j = j + 1) begin
      average_length_code = j;
      blk = 2 << j;
      sh = j + 1;
      burst(2 * blk);
    end
    average_select = 1'b0;
    blk = 0;
    // Hold word from the last sample, then from the pipeline's last stage
    for (j = 1; j >= 0; j = j - 1) begin
      hold_source_last = j;
      burst(3);
      holdover_pin = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk(synth_tuning_word, j ? c : c_prev);
      hold_now = 1'b1;
      hw = synth_tuning_word;
      burst(2);
      chk(synth_tuning_word, hw);
      hold_now = 1'b0;
      holdover_pin = 1'b0;
      for (n = 0; n < 20 && loop_restart !== 1'b1; n = n + 1) @(negedge clk_sys);
      chk(loop_restart, 1'b1);
      chk(loop_seed_word, hw);
    end
    // Recovery with codes 0 and 3; the second run faults again before expiry
    auto_holdover = 1'b1;
    auto_recovery = 1'b1;
    for (j = 0; j < 2; j = j + 1) begin
      recovery_code = j ? 5'h03 : 5'h00;
      fail1 = 1'b1;
      fail2 = 1'b1;
      repeat (12) @(negedge clk_sys);
      fail1 = 1'b0;
      if (j) repeat (6) @(negedge clk_sys);
      fail1 = j;
      if (j) repeat (4) @(negedge clk_sys);
      fail1 = 1'b0;
      for (n = 0; n < 100 && first_reference_valid !== 1'b1; n = n + 1) @(negedge clk_sys);
      if (j) chk(n - n0, 48'h0000_0000_000e);
      n0 = n;
    end
    repeat (2) @(negedge clk_sys);
    chk(second_reference_valid, 1'b0);
    chk({holdover_active, auto_switch_second, auto_switch_request}, 3'h1);
    recovery_timer_disable = 1'b1;
    validate_second_reference = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({first_reference_valid, second_reference_valid}, 2'h1);
    // Tick every 4 cycles: expiry waits up to 3 cycles more than at full rate
    {recovery_timer_disable, recovery_code, rate_exponent, fail1} = {1'b0, 5'h00, 5'h02, 1'b1};
    repeat (12) @(negedge clk_sys);
    fail1 = 1'b0;
    for (n = 0; n < 100 && first_reference_valid !== 1'b1; n = n + 1) @(negedge clk_sys);
    chk(n >= 6 && n <= 9, 1'b1);
    chk(exp_q.size(), 48'h0000_0000_0000);
    final_report;
  end
endmodule // holdover_recovery_tuning_control_tb
